// ==== arith_regs.svh ====
`ifndef ARITH_REGS_SVH
`define ARITH_REGS_SVH

// ==========================================
// Special register addresses in the direct space
`define SFR_ACC 8'hE0
`define SFR_B 8'hF0
`define SFR_STATUS 8'hD0
`define SFR_SP 8'h81
`define SFR_DPL 8'h82
`define SFR_DPH 8'h83
// Direct address bit that selects the special register half
`define DIRECT_SFR_BIT 7

// ==========================================
// Status word field positions
`define STATUS_CARRY 7
`define STATUS_NIBBLE_CARRY 6
`define STATUS_USER 5
`define STATUS_BANK_HIGH 4
`define STATUS_BANK_LOW 3
`define STATUS_OVERFLOW 2
`define STATUS_PARITY 0

// ==========================================
// Reset values
`define ACC_RESET 8'h00
`define B_RESET 8'h00
`define STATUS_RESET 8'h00
`define SP_RESET 8'h07
`define DATA_POINTER_RESET 16'h0000

// ==========================================
// Decimal adjust constants
`define DA_LOW_FIX 9'h006
`define DA_HIGH_FIX 9'h060
`define DA_NIBBLE_MAX 4'h9

`endif

// ==== arith_pkg.sv ====
package arith_pkg;

	// ==========================================
	// Operations
	typedef enum logic [3:0] {
		op_add,
		add_with_carry_to_acc,
		op_subtract_borrow,
		op_inc_acc,
		op_inc_byte,
		op_inc_data_pointer,
		multiply_acc_by_b,
		divide_acc_by_b,
		decimal_adjust_op,
		op_table_read,
		op_load_acc,
		op_store_acc
	} op_t;

	// ==========================================
	// Addressing modes
	typedef enum logic [3:0] {
		mode_direct,
		mode_ind_bank,
		mode_ind_stack,
		mode_ind_pointer16,
		mode_register,
		mode_specific,
		mode_immediate,
		mode_idx_pointer16,
		mode_idx_pc
	} mode_t;

	// Operand spaces
	typedef enum logic [2:0] {
		space_iram,
		space_sfr,
		space_xdata,
		space_code,
		space_imm,
		space_acc,
		space_none
	} space_t;

	// Controller states, one-hot
	typedef enum logic [3:0] {
		st_idle = 4'b0001,
		st_ptr = 4'b0010,
		st_read = 4'b0100,
		st_exec = 4'b1000
	} state_t;

	// ==========================================
	// Carriers
	typedef struct packed {
		op_t op;
		mode_t mode;
		logic [2:0] reg_num;
		logic [7:0] addr_field;
		logic [7:0] imm;
		logic [15:0] pc;
	} cmd_t;

	typedef struct packed {
		space_t space;
		logic [15:0] addr;
	} loc_t;

	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] b;
		logic [7:0] byte_res;
		logic carry;
		logic nibble_carry;
		logic overflow;
		logic set_carry;
		logic set_nibble_carry;
		logic set_overflow;
		logic wr_acc;
		logic wr_b;
	} alu_out_t;

	typedef struct packed {
		logic req;
		logic write;
		logic code;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mem_req_t;

	// Bank register address: bank select above the register number
	function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] rnum);
		bank_addr = {3'b000, bank, rnum};
	endfunction : bank_addr

endpackage : arith_pkg

// ==== arith_unit.sv ====
`timescale 1ns/10ps
`include "arith_regs.svh"

module arith_unit (
	input arith_pkg::op_t op,
	input logic [7:0] acc,
	input logic [7:0] operand,
	input logic [7:0] b_val,
	input logic carry_in,
	input logic nibble_carry_in,
	output arith_pkg::alu_out_t res
);
	import arith_pkg::*;

	// ==========================================
	// Result and flag computation
	always_comb begin
		logic [8:0] sum;
		logic [4:0] nib;
		logic [15:0] prod;
		logic [8:0] adj;
		logic cin;
		sum = '0;
		nib = '0;
		prod = '0;
		adj = '0;
		cin = 1'b0;
		res = '0;
		case (op)
			op_add, add_with_carry_to_acc: begin
				cin = (op == add_with_carry_to_acc) & carry_in;
				sum = {1'b0, acc} + {1'b0, operand} + {8'h00, cin};
				nib = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
				res.acc = sum[7:0];
				res.carry = sum[8];
				res.nibble_carry = nib[4];
				res.overflow = (acc[7] == operand[7]) & (sum[7] != acc[7]);
				res.set_carry = 1'b1;
				res.set_nibble_carry = 1'b1;
				res.set_overflow = 1'b1;
				res.wr_acc = 1'b1;
			end
			op_subtract_borrow: begin
				sum = {1'b0, acc} - {1'b0, operand} - {8'h00, carry_in};
				nib = {1'b0, acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, carry_in};
				res.acc = sum[7:0];
				res.carry = sum[8];
				res.nibble_carry = ~nib[4];
				res.overflow = (acc[7] != operand[7]) & (sum[7] != acc[7]);
				res.set_carry = 1'b1;
				res.set_nibble_carry = 1'b1;
				res.set_overflow = 1'b1;
				res.wr_acc = 1'b1;
			end
			op_inc_acc: begin
				res.acc = acc + 8'h01;
				res.wr_acc = 1'b1;
			end
			op_inc_byte: begin
				res.byte_res = operand + 8'h01;
			end
			multiply_acc_by_b: begin
				prod = {8'h00, acc} * {8'h00, b_val};
				res.acc = prod[7:0];
				res.b = prod[15:8];
				res.overflow = |prod[15:8];
				res.set_carry = 1'b1;
				res.set_overflow = 1'b1;
				res.wr_acc = 1'b1;
				res.wr_b = 1'b1;
			end
			divide_acc_by_b: begin
				res.set_carry = 1'b1;
				res.set_overflow = 1'b1;
				if (b_val == 8'h00) begin
					res.overflow = 1'b1;
				end else begin
					res.acc = acc / b_val;
					res.b = acc % b_val;
					res.wr_acc = 1'b1;
					res.wr_b = 1'b1;
				end
			end
			decimal_adjust_op: begin
				adj = {1'b0, acc};
				if ((adj[3:0] > `DA_NIBBLE_MAX) | nibble_carry_in) begin
					adj = adj + `DA_LOW_FIX;
				end
				if ((adj[7:4] > `DA_NIBBLE_MAX) | carry_in | adj[8]) begin
					adj = adj + `DA_HIGH_FIX;
					adj[8] = 1'b1;
				end
				res.acc = adj[7:0];
				res.carry = adj[8] | carry_in;
				res.set_carry = 1'b1;
				res.wr_acc = 1'b1;
			end
			op_table_read, op_load_acc: begin
				res.acc = operand;
				res.wr_acc = 1'b1;
			end
			op_store_acc: begin
				res.byte_res = acc;
			end
			default: begin
				res = '0;
			end
		endcase
	end

endmodule : arith_unit

// ==== operand_locator.sv ====
`timescale 1ns/10ps
`include "arith_regs.svh"

module operand_locator (
	input arith_pkg::cmd_t cmd,
	input logic [1:0] bank,
	input logic [7:0] ptr,
	input logic [7:0] sp,
	input logic [7:0] acc,
	input logic [15:0] data_ptr,
	output arith_pkg::loc_t loc
);
	import arith_pkg::*;

	// ==========================================
	// Operand location per addressing mode
	always_comb begin
		loc.space = space_none;
		loc.addr = 16'h0000;
		case (cmd.mode)
			mode_direct: begin
				loc.addr = {8'h00, cmd.addr_field};
				loc.space = cmd.addr_field[`DIRECT_SFR_BIT] ? space_sfr : space_iram;
			end
			mode_ind_bank: begin
				loc.space = space_iram;
				loc.addr = {8'h00, ptr};
			end
			mode_ind_stack: begin
				loc.space = space_iram;
				loc.addr = {8'h00, sp};
			end
			mode_ind_pointer16: begin
				loc.space = space_xdata;
				loc.addr = data_ptr;
			end
			mode_register: begin
				loc.space = space_iram;
				loc.addr = {8'h00, bank_addr(bank, cmd.reg_num)};
			end
			mode_specific: begin
				loc.space = space_acc;
			end
			mode_immediate: begin
				loc.space = space_imm;
			end
			mode_idx_pointer16: begin
				loc.space = space_code;
				loc.addr = data_ptr + {8'h00, acc};
			end
			mode_idx_pc: begin
				loc.space = space_code;
				loc.addr = cmd.pc + {8'h00, acc};
			end
			default: begin
				loc.space = space_none;
			end
		endcase
	end

endmodule : operand_locator

// ==== operand_addressing_arith.sv ====
`timescale 1ns/10ps
`include "arith_regs.svh"

// Overview of operation
// - Direct mode takes the operand location from the instruction's 8-bit field.
// - Direct reaches internal RAM and special registers; 80h-FFh selects special registers.
// - Indirect mode reads the operand address from a named register; internal and external.
// - 8-bit indirect uses only bank pointer 0, pointer 1, or stack pointer.
// - 16-bit indirect uses only the 16-bit data pointer.
// - Register mode decodes a 3-bit register number from the opcode.
// - The bank comes from the status word bank bits at execution time.
// - Register-specific instructions imply their target, such as the accumulator.
// - Immediate mode takes the operand from bytes following the opcode.
// - Indexed mode reads program memory only; indexed writes are refused.
// - Indexed address is accumulator plus data pointer or program counter.
// - Any internal data byte can be incremented in place.
// - The 16-bit data pointer increments as one operation with carry.
// - Multiply puts the product high byte in B, low byte in accumulator.
// - Divide leaves quotient in accumulator and remainder in B.
// - Add to accumulator takes direct, indirect, register or immediate operands.
// - Bank select maps banks 0-3 to consecutive 8-byte blocks at RAM bottom.
// - Signed add or subtract sets overflow outside +127 to -128.
// - Parity flag keeps accumulator ones plus flag even, always.
// - Auxiliary carry: carry out of bit 3, or no borrow from bit 4.

module operand_addressing_arith #(
	parameter int IRAM_DEPTH = 256
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input arith_pkg::cmd_t cmd,
	output logic cmd_ready,
	output logic done,
	output logic refused,
	output arith_pkg::mem_req_t mem,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_ack,
	output logic [7:0] acc,
	output logic [7:0] b_reg,
	output logic [7:0] cpu_status_word,
	output logic [7:0] sp,
	output logic [15:0] data_pointer_16
);
	import arith_pkg::*;

	// ==========================================
	// Parameter check
	generate
		if (IRAM_DEPTH != 128 && IRAM_DEPTH != 256) begin : g_depth_check
			$error("IRAM_DEPTH must be 128 or 256");
		end
	endgenerate

	// ==========================================
	// Storage and state
	logic [7:0] iram [0:IRAM_DEPTH-1];
	state_t state;
	cmd_t cur;
	logic [7:0] ptr;
	logic [7:0] operand;
	loc_t loc;
	alu_out_t alu;
	logic [1:0] bank;
	logic [7:0] iram_rd;
	logic [7:0] ptr_rd;
	logic [7:0] sfr_rd;
	logic [7:0] int_val;
	logic is_ext;
	logic writes_loc;
	logic bad;
	logic wr_loc;
	logic wr_iram;
	logic wr_sfr;
	logic [7:0] wr_val;
	logic [7:0] next_acc;

	// Internal RAM range test
	function automatic logic in_iram(input logic [15:0] a);
		in_iram = (a < 16'(IRAM_DEPTH));
	endfunction : in_iram

	// Bank bits taken from the live status word
	assign bank = {cpu_status_word[`STATUS_BANK_HIGH], cpu_status_word[`STATUS_BANK_LOW]};

	// ==========================================
	// Operand location and arithmetic
	operand_locator u_locator (
		.cmd(cur),
		.bank(bank),
		.ptr(ptr),
		.sp(sp),
		.acc(acc),
		.data_ptr(data_pointer_16),
		.loc(loc)
	);

	arith_unit u_alu (
		.op(cur.op),
		.acc(acc),
		.operand(operand),
		.b_val(b_reg),
		.carry_in(cpu_status_word[`STATUS_CARRY]),
		.nibble_carry_in(cpu_status_word[`STATUS_NIBBLE_CARRY]),
		.res(alu)
	);

	// ==========================================
	// Internal reads
	always_comb begin
		iram_rd = 8'h00;
		ptr_rd = 8'h00;
		if (in_iram(loc.addr)) begin
			iram_rd = iram[loc.addr[7:0]];
		end
		// Bank pointer 0 or 1 only, selected by the low register bit
		if (in_iram({8'h00, bank_addr(bank, {2'b00, cur.reg_num[0]})})) begin
			ptr_rd = iram[bank_addr(bank, {2'b00, cur.reg_num[0]})];
		end
	end

	// Special register read decode; unmapped addresses read zero
	always_comb begin
		case (loc.addr[7:0])
			`SFR_ACC: sfr_rd = acc;
			`SFR_B: sfr_rd = b_reg;
			`SFR_STATUS: sfr_rd = cpu_status_word;
			`SFR_SP: sfr_rd = sp;
			`SFR_DPL: sfr_rd = data_pointer_16[7:0];
			`SFR_DPH: sfr_rd = data_pointer_16[15:8];
			default: sfr_rd = 8'h00;
		endcase
	end

	// Operand value for spaces answered inside the core
	always_comb begin
		case (loc.space)
			space_iram: int_val = iram_rd;
			space_sfr: int_val = sfr_rd;
			space_imm: int_val = cur.imm;
			space_acc: int_val = acc;
			default: int_val = 8'h00;
		endcase
	end

	// Access classification and refusal
	always_comb begin
		is_ext = (loc.space == space_xdata) | (loc.space == space_code);
		writes_loc = (cur.op == op_store_acc) | (cur.op == op_inc_byte);
		bad = 1'b0;
		if (writes_loc && (loc.space == space_code || loc.space == space_imm)) begin
			bad = 1'b1;
		end
		if (writes_loc && loc.space == space_none) begin
			bad = 1'b1;
		end
		if (cur.op == op_inc_byte && loc.space == space_xdata) begin
			bad = 1'b1;
		end
		if (cur.op == op_table_read && loc.space != space_code) begin
			bad = 1'b1;
		end
	end

	// Write-back to the addressed location
	always_comb begin
		wr_loc = (state == st_exec) & writes_loc;
		wr_val = alu.byte_res;
		wr_iram = wr_loc & (loc.space == space_iram) & in_iram(loc.addr);
		wr_sfr = wr_loc & (loc.space == space_sfr);
	end

	// Next accumulator value
	always_comb begin
		next_acc = acc;
		if (state == st_exec && alu.wr_acc) begin
			next_acc = alu.acc;
		end else if (wr_loc && loc.space == space_acc) begin
			next_acc = wr_val;
		end else if (wr_sfr && loc.addr[7:0] == `SFR_ACC) begin
			next_acc = wr_val;
		end
	end

	// ==========================================
	// Controller
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= st_idle;
		end else begin
			case (state)
				st_idle: begin
					if (cmd_valid) begin
						state <= st_ptr;
					end
				end
				st_ptr: begin
					state <= st_read;
				end
				st_read: begin
					if (bad) begin
						state <= st_idle;
					end else if (!is_ext || mem_ack) begin
						state <= st_exec;
					end
				end
				st_exec: begin
					state <= st_idle;
				end
				default: begin
					state <= st_idle;
				end
			endcase
		end
	end

	// Command capture
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cur <= '0;
		end else if (state == st_idle && cmd_valid) begin
			cur <= cmd;
		end
	end

	// Handshake outputs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmd_ready <= 1'b1;
			done <= 1'b0;
			refused <= 1'b0;
		end else begin
			done <= (state == st_exec);
			refused <= (state == st_read) & bad;
			if (state == st_idle && cmd_valid) begin
				cmd_ready <= 1'b0;
			end else if (state == st_exec || (state == st_read && bad)) begin
				cmd_ready <= 1'b1;
			end
		end
	end

	// Pointer fetch from the selected bank
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ptr <= 8'h00;
		end else if (state == st_ptr) begin
			ptr <= ptr_rd;
		end
	end

	// Operand latch
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			operand <= 8'h00;
		end else if (state == st_read && !bad) begin
			if (!is_ext) begin
				operand <= int_val;
			end else if (mem_ack) begin
				operand <= mem_rdata;
			end
		end
	end

	// External data and program memory requests
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mem <= '0;
		end else if (mem_ack) begin
			mem.req <= 1'b0;
		end else if (state == st_read && is_ext && !bad && !mem.req) begin
			mem.req <= 1'b1;
			mem.write <= (cur.op == op_store_acc);
			mem.code <= (loc.space == space_code);
			mem.addr <= loc.addr;
			mem.wdata <= acc;
		end
	end

	// ==========================================
	// Internal RAM write
	always_ff @(posedge clk) begin
		if (wr_iram) begin
			iram[loc.addr[7:0]] <= wr_val;
		end
	end

	// Accumulator
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			acc <= `ACC_RESET;
		end else begin
			acc <= next_acc;
		end
	end

	// B register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			b_reg <= `B_RESET;
		end else if (state == st_exec && alu.wr_b) begin
			b_reg <= alu.b;
		end else if (wr_sfr && loc.addr[7:0] == `SFR_B) begin
			b_reg <= wr_val;
		end
	end

	// Stack pointer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sp <= `SP_RESET;
		end else if (wr_sfr && loc.addr[7:0] == `SFR_SP) begin
			sp <= wr_val;
		end
	end

	// Data pointer: one 16-bit increment, or byte writes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			data_pointer_16 <= `DATA_POINTER_RESET;
		end else if (state == st_exec && cur.op == op_inc_data_pointer) begin
			data_pointer_16 <= data_pointer_16 + 16'h0001;
		end else if (wr_sfr && loc.addr[7:0] == `SFR_DPL) begin
			data_pointer_16[7:0] <= wr_val;
		end else if (wr_sfr && loc.addr[7:0] == `SFR_DPH) begin
			data_pointer_16[15:8] <= wr_val;
		end
	end

	// Status word: software write, then arithmetic flags, parity every cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cpu_status_word <= `STATUS_RESET;
		end else begin
			if (wr_sfr && loc.addr[7:0] == `SFR_STATUS) begin
				cpu_status_word <= wr_val;
			end
			if (state == st_exec && alu.set_carry) begin
				cpu_status_word[`STATUS_CARRY] <= alu.carry;
			end
			if (state == st_exec && alu.set_nibble_carry) begin
				cpu_status_word[`STATUS_NIBBLE_CARRY] <= alu.nibble_carry;
			end
			if (state == st_exec && alu.set_overflow) begin
				cpu_status_word[`STATUS_OVERFLOW] <= alu.overflow;
			end
			cpu_status_word[`STATUS_PARITY] <= ^next_acc;
		end
	end

endmodule : operand_addressing_arith

// ==== operand_addressing_arith_chk.sv ====
`timescale 1ns/10ps

module operand_addressing_arith_chk #(
	parameter int IRAM_DEPTH = 256
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input arith_pkg::cmd_t cmd,
	input wire logic cmd_ready,
	input wire logic done,
	input wire logic refused,
	input arith_pkg::mem_req_t mem,
	input wire logic mem_ack,
	input wire logic [7:0] acc,
	input wire logic [7:0] b_reg,
	input wire logic [7:0] cpu_status_word,
	input wire logic [15:0] data_pointer_16
);
	import arith_pkg::*;
	logic take;
	cmd_t cmd_q;
	logic [7:0] acc_q;
	logic [7:0] b_q;
	assign take = cmd_valid && cmd_ready;
	// Operands as they stood when the command was taken
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmd_q <= '0;
			acc_q <= 8'h00;
			b_q <= 8'h00;
		end else if (take) begin
			cmd_q <= cmd;
			acc_q <= acc;
			b_q <= b_reg;
		end
	end
	default clocking dc @(posedge clk); endclocking
	default disable iff (!resetn);
	// ==========================================
	// Checks
	AST_PARITY: assert property (cpu_status_word[0] == ^acc)
		else $error("parity flag disagrees with accumulator");
	AST_MUL: assert property (take && cmd.op == multiply_acc_by_b |-> ##4 done
		&& {b_reg, acc} == 16'(acc_q) * 16'(b_q)) else $error("bad product");
	AST_DIV: assert property (take && cmd.op == divide_acc_by_b && b_reg != 8'h00 |-> ##4
		done && acc == acc_q / b_q && b_reg == acc_q % b_q && !cpu_status_word[2])
		else $error("bad quotient or remainder");
	AST_DIV0: assert property (take && cmd.op == divide_acc_by_b && b_reg == 8'h00 |->
		##4 done && cpu_status_word[2] && !cpu_status_word[7]) else $error("bad zero divide");
	AST_INC_DP: assert property (take && cmd.op == op_inc_data_pointer |-> ##4 done
		&& data_pointer_16 == $past(data_pointer_16, 4) + 16'h0001) else $error("bad pointer step");
	AST_ADD_IMM: assert property (take && cmd.op == op_add && cmd.mode == mode_immediate
		|-> ##4 done && acc == acc_q + cmd_q.imm) else $error("bad immediate add");
	AST_IDX_DP: assert property (mem.req && cmd_q.op == op_table_read
		&& cmd_q.mode == mode_idx_pointer16 |-> mem.code && !mem.write
		&& mem.addr == data_pointer_16 + {8'h00, acc}) else $error("bad table address");
	AST_TBL_REFUSE: assert property (take && cmd.op == op_table_read
		&& !(cmd.mode inside {mode_idx_pointer16, mode_idx_pc}) |-> ##3 refused && !done)
		else $error("table read outside indexed mode not refused");
	C_MUL: cover property (take && cmd.op == multiply_acc_by_b);
	C_CODE: cover property (mem_ack && mem.code);
	C_REF: cover property (refused);
endmodule : operand_addressing_arith_chk

bind operand_addressing_arith operand_addressing_arith_chk #(.IRAM_DEPTH(IRAM_DEPTH)) chk_u (
	.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
	.done(done), .refused(refused), .mem(mem), .mem_ack(mem_ack), .acc(acc), .b_reg(b_reg),
	.cpu_status_word(cpu_status_word), .data_pointer_16(data_pointer_16));

// ==== mem_model.sv ====
`timescale 1ns/10ps

module mem_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic slow,
	input arith_pkg::mem_req_t mem,
	output logic [7:0] mem_rdata,
	output logic mem_ack,
	output logic [15:0] last_addr
);
	import arith_pkg::*;
	logic [7:0] xdata [0:255];
	logic [1:0] wait_n;
	// Answer each request after one cycle, or after four when slow
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mem_ack <= 1'b0;
			mem_rdata <= 8'hA5;
			wait_n <= 2'h0;
			last_addr <= 16'h0000;
		end else if (mem.req && !mem_ack && (!slow || wait_n == 2'h3)) begin
			mem_ack <= 1'b1;
			last_addr <= mem.addr;
			wait_n <= 2'h0;
			if (mem.write) begin
				xdata[mem.addr[7:0]] <= mem.wdata;
			end
			mem_rdata <= mem.code ? (mem.addr[7:0] ^ 8'h5A) : xdata[mem.addr[7:0]];
		end else begin
			mem_ack <= 1'b0;
			wait_n <= mem.req ? wait_n + 2'h1 : 2'h0;
			mem_rdata <= ~mem_rdata; // Stale data never looks valid
		end
	end
endmodule : mem_model

// ==== operand_addressing_arith_bench.sv ====
`timescale 1ns/10ps

module operand_addressing_arith_bench;
	import arith_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic cmd_valid = 1'b0;
	cmd_t cmd = '0;
	logic slow = 1'b0;
	logic cmd_ready, done, refused, mem_ack;
	mem_req_t mem;
	logic [7:0] mem_rdata, acc, b_reg, cpu_status_word, sp;
	logic [15:0] data_pointer_16, last_addr;
	logic [1:0] res;
	int fails = 0;
	int compares = 0;

	// Clock of 50 ns
	always #25 clk = ~clk;

	operand_addressing_arith #(.IRAM_DEPTH(256)) dut_u (.clk(clk), .resetn(resetn),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .done(done),
		.refused(refused), .mem(mem), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .acc(acc),
		.b_reg(b_reg), .cpu_status_word(cpu_status_word), .sp(sp),
		.data_pointer_16(data_pointer_16));
	mem_model mem_u (.clk(clk), .resetn(resetn), .slow(slow), .mem(mem),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .last_addr(last_addr));

	// ==========================================
	// Shared tasks
	task automatic wrap_up;
		$display("Counts: %0d compares, %0d fails", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk16

	task automatic run(input op_t o, input mode_t m, input logic [7:0] a, input logic [7:0] i);
		int n = 0;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= '{op: o, mode: m, reg_num: a[2:0], addr_field: a, imm: i, pc: 16'h2000};
		@(posedge clk);
		cmd_valid <= 1'b0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (done !== 1'b1 && refused !== 1'b1 && n < 40);
		if (n >= 40) begin
			fails++;
			$display("MISMATCH at %0t: command not answered", $time);
		end
		res = {refused, done};
	endtask : run

	task automatic ld(input logic [7:0] v);
		run(op_load_acc, mode_immediate, 8'h00, v);
	endtask : ld

	task automatic st(input logic [7:0] a);
		run(op_store_acc, mode_direct, a, 8'h00);
	endtask : st

	// ==========================================
	// Scenarios
	task automatic t_add;
		ld(8'h7F);
		chk8(acc, 8'h7F);
		run(op_add, mode_immediate, 8'h00, 8'h01);
		chk8(acc, 8'h80);
		chk8(cpu_status_word, 8'h45);
		$display("Add test done");
	endtask : t_add

	task automatic t_direct;
		st(8'h30);
		run(op_inc_byte, mode_direct, 8'h30, 8'h00);
		run(op_load_acc, mode_direct, 8'h30, 8'h00);
		chk8(acc, 8'h81);
		ld(8'h5C);
		st(8'hF0);
		chk8(b_reg, 8'h5C);
		ld(8'h30);
		st(8'h01);
		ld(8'h02);
		run(op_add, mode_ind_bank, 8'h01, 8'h00);
		chk8(acc, 8'h83);
		ld(8'h11);
		st(8'h07);
		ld(8'h01);
		run(op_add, mode_ind_stack, 8'h00, 8'h00);
		chk8(acc, 8'h12);
		$display("Direct and indirect test done");
	endtask : t_direct

	task automatic t_bank;
		for (int k = 0; k < 4; k++) begin
			ld({3'b000, 2'(k), 3'b000});
			st(8'hD0);
			ld(8'h60 + 8'(k));
			run(op_store_acc, mode_register, 8'h05, 8'h00);
		end
		ld(8'h00);
		st(8'hD0);
		for (int k = 0; k < 4; k++) begin
			run(op_load_acc, mode_direct, {3'b000, 2'(k), 3'b101}, 8'h00);
			chk8(acc, 8'h60 + 8'(k));
		end
		$display("Bank test done");
	endtask : t_bank

	task automatic t_muldiv;
		ld(8'hA0);
		st(8'hF0);
		ld(8'h50);
		run(multiply_acc_by_b, mode_specific, 8'h00, 8'h00);
		chk16({b_reg, acc}, 16'h3200);
		ld(8'h12);
		st(8'hF0);
		ld(8'hFB);
		run(divide_acc_by_b, mode_specific, 8'h00, 8'h00);
		chk16({b_reg, acc}, 16'h110D);
		chk8(cpu_status_word & 8'h84, 8'h00);
		ld(8'h00);
		st(8'hF0);
		ld(8'h33);
		run(divide_acc_by_b, mode_specific, 8'h00, 8'h00);
		chk8(cpu_status_word & 8'h84, 8'h04);
		$display("Multiply and divide test done");
	endtask : t_muldiv

	task automatic t_daa;
		ld(8'h38);
		run(op_add, mode_immediate, 8'h00, 8'h49);
		run(decimal_adjust_op, mode_specific, 8'h00, 8'h00);
		chk8(acc, 8'h87);
		ld(8'h99);
		run(op_add, mode_immediate, 8'h00, 8'h01);
		run(decimal_adjust_op, mode_specific, 8'h00, 8'h00);
		chk16({acc, cpu_status_word & 8'h80}, 16'h0080);
		$display("Decimal adjust test done");
	endtask : t_daa

	task automatic t_xmem;
		slow <= 1'b1;
		ld(8'hFF);
		st(8'h82);
		ld(8'h00);
		st(8'h83);
		run(op_inc_data_pointer, mode_specific, 8'h00, 8'h00);
		chk16(data_pointer_16, 16'h0100);
		ld(8'h05);
		run(op_table_read, mode_idx_pointer16, 8'h00, 8'h00);
		chk16({last_addr[7:0], acc}, 16'h055F);
		slow <= 1'b0;
		run(op_table_read, mode_idx_pc, 8'h00, 8'h00);
		chk16({last_addr[15:8], acc}, 16'h2005);
		run(op_store_acc, mode_ind_pointer16, 8'h00, 8'h00);
		chk16(last_addr, 16'h0100);
		ld(8'h00);
		run(op_load_acc, mode_ind_pointer16, 8'h00, 8'h00);
		chk8(acc, 8'h05);
		$display("External memory test done");
	endtask : t_xmem

	task automatic t_refuse;
		ld(8'h3C);
		for (int m = 0; m < 7; m++) begin
			run(op_table_read, mode_t'(m), 8'h30, 8'h00);
			chk8({6'h00, res}, 8'h02);
		end
		run(op_store_acc, mode_idx_pc, 8'h00, 8'h00);
		chk8({6'h00, res}, 8'h02);
		run(op_inc_byte, mode_ind_pointer16, 8'h00, 8'h00);
		chk8({6'h00, res}, 8'h02);
		chk8(acc, 8'h3C);
		$display("Refusal test done");
	endtask : t_refuse

	// Carry-in add, register and direct adds, subtract flags, accumulator step
	task automatic t_alu;
		ld(8'h10);
		run(add_with_carry_to_acc, mode_immediate, 8'h00, 8'h05);
		chk8(acc, 8'h16);
		run(op_add, mode_register, 8'h05, 8'h00);
		run(op_add, mode_direct, 8'h30, 8'h00);
		chk8(acc, 8'hF7);
		ld(8'h80);
		run(op_subtract_borrow, mode_immediate, 8'h00, 8'h01);
		chk8(cpu_status_word, 8'h05);
		run(op_inc_acc, mode_specific, 8'h00, 8'h00);
		chk8(acc, 8'h80);
		$display("Carry and subtract test done");
	endtask : t_alu

	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		chk8(sp, 8'h07);
		t_add;
		t_direct;
		t_bank;
		t_muldiv;
		t_daa;
		t_alu;
		t_xmem;
		t_refuse;
		wrap_up;
	end

	// Watchdog well beyond the expected run length
	initial begin
		#(50 * 20000);
		fails++;
		$display("MISMATCH at %0t: run did not finish", $time);
		wrap_up;
	end
endmodule : operand_addressing_arith_bench
